// ---- include/lpm_defs.svh ----
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define OFS_CTRL      8'h00
`define OFS_FREQ      8'h04
`define OFS_STATUS    8'h08
`define OFS_IRQ_STAT  8'h0C
`define OFS_IRQ_MASK  8'h10
`define OFS_WAKE_EN   8'h14

`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  2
`define CTRL_LPRUN     3
`define CTRL_RANGE_LSB 4
`define CTRL_RANGE_MSB 5
`define CTRL_SRC_MSI   6
`define CTRL_SLOWI     7
`define CTRL_SLOWX     8

`define MODE_SLEEP      3'h0
`define MODE_LPSLEEP    3'h1
`define MODE_STOP_CAL   3'h2
`define MODE_STOP_NOCAL 3'h3
`define MODE_STBY_CAL   3'h4
`define MODE_STBY_NOCAL 3'h5

`define IRQ_WAKE  0
`define IRQ_LPREF 1
`define IRQ_OVER  2
`define IRQ_PACE  3

`define RANGE_RST   2'h2
`define SRC_MSI_RST 1'h1
`define FREQ_RST    16'h0831

`define LPRUN_MAX_KHZ   131
`define RANGE1_CAP_KHZ  32000
`define RANGE2_CAP_KHZ  16000
`define RANGE3_CAP_KHZ  4000
`define RANGE1_WS_KHZ   16000
`define RANGE2_WS_KHZ   8000
`define RANGE3_WS_KHZ   2100

`define CLK_MHZ         40
`define CLK_NS          (1000 / `CLK_MHZ)
`define STOP_WAKE_NS    8000
`define STOP_WAKE_CYC   (`STOP_WAKE_NS / `CLK_NS)
`define STBY_WAKE_NS    60000
`define STBY_WAKE_CYC   (`STBY_WAKE_NS / `CLK_NS)
`define STEP_GAP_NS     5000
`define STEP_GAP_CYC    ((`STEP_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define REG_SETTLE_NS   1000
`define REG_SETTLE_CYC  ((`REG_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- include/lpm_pkg.sv ----
package lpm_pkg;

  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_STOP, ST_STBY, ST_WAKE} state_t;

  typedef struct packed {
    logic        ext_reset_pin_n;
    logic        wdg_reset;
    logic [2:0]  wake_pin;
    logic        usb_wake;
    logic        cal_wake;
    logic        tstamp;
    logic        tamper;
    logic [1:0]  cal_alarm;
    logic [1:0]  comp;
    logic        supply_level_detector;
    logic [15:0] ext_interrupt_line;
  } wake_src_t;

  typedef struct packed {
    logic cpu_en;
    logic core_en;
    logic pll_en;
    logic multispeed_osc_en;
    logic fast_internal_osc_en;
    logic fast_crystal_osc_en;
    logic slow_internal_osc_en;
    logic slow_crystal_osc_en;
    logic reg_lp;
    logic reg_off;
    logic core_pwr_off;
  } clk_ctl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    state_t      st;
    logic        lp_sleep;
    logic        cal_on;
    logic [2:0]  mode;
    logic        lp_run;
    logic [1:0]  range;
    logic        src_msi;
    logic        slowi_en;
    logic        slowx_en;
    logic [15:0] freq;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    wake_src_t   wake_en;
    clk_ctl_t    clk;
    logic        ws;
    logic        irq;
    logic        core_rst;
    logic [11:0] cnt;
    logic        wait_r;
    logic [31:0] rdata;
  } lpm_state_t;

endpackage : lpm_pkg

// ---- design/wake_sync.sv ----
`timescale 1ns/1ps

module wake_sync #(
  parameter int W = 31
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // s1 feeds only s2; edges are taken from s2/s3
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = i_async;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.s2;

  for (genvar g = 0; g < W; g++) begin : g_rise
    assign o_rise[g] = s_r.s2[g] & ~s_r.s3[g];
  end

endmodule : wake_sync

// ---- design/freq_guard.sv ----
`timescale 1ns/1ps
`include "lpm_defs.svh"

module freq_guard (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [1:0]  i_range,
  input  wire logic        i_src_msi,
  input  wire logic [15:0] i_freq_khz,
  input  wire logic        i_freq_wr,
  input  wire logic [15:0] i_new_khz,
  output logic             o_one_wait_state,
  output logic             o_over_cap,
  output logic             o_pace_err
);

  typedef struct packed {
    logic [7:0] gap;
    logic       ws;
    logic       over;
    logic       pace;
  } guard_t;

  guard_t s_r;
  guard_t s_nxt;

  always_comb begin
    logic [15:0] cap;
    logic [15:0] thr;
    logic        need_msi;
    cap      = 16'(`RANGE3_CAP_KHZ);
    thr      = 16'(`RANGE3_WS_KHZ);
    need_msi = 1'b1;
    s_nxt      = s_r;
    s_nxt.pace = 1'b0;
    // range code 0 is treated as the most restrictive range
    unique case (i_range)
      2'h1: begin
        cap      = 16'(`RANGE1_CAP_KHZ);
        thr      = 16'(`RANGE1_WS_KHZ);
        need_msi = 1'b0;
      end
      2'h2: begin
        cap      = 16'(`RANGE2_CAP_KHZ);
        thr      = 16'(`RANGE2_WS_KHZ);
        need_msi = 1'b0;
      end
      default: ;
    endcase
    s_nxt.ws   = i_freq_khz > thr;
    s_nxt.over = (i_freq_khz > cap) || (need_msi && !i_src_msi);
    if (s_r.gap != 8'h00) begin
      s_nxt.gap = s_r.gap - 8'h01;
    end
    // only flagged: the pacing duty lies with whoever reprograms the clock
    if (i_freq_wr) begin
      s_nxt.gap = 8'(`STEP_GAP_CYC);
      if (s_r.gap != 8'h00 ||
          (i_new_khz > i_freq_khz && {2'b00, i_new_khz} >= {i_freq_khz, 2'b00})) begin
        s_nxt.pace = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_one_wait_state = s_r.ws;
  assign o_over_cap       = s_r.over;
  assign o_pace_err       = s_r.pace;

endmodule : freq_guard

// ---- design/low_power_mode_controller.sv ----
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "lpm_defs.svh"

module low_power_mode_controller (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire lpm_pkg::av_req_t   i_av,
  output logic [31:0]             o_av_readdata,
  output logic                    o_av_waitrequest,
  input  wire logic               i_cpu_idle,
  input  wire logic               i_periph_evt,
  input  wire logic               i_vref_on,
  input  wire lpm_pkg::wake_src_t i_wake,
  output lpm_pkg::clk_ctl_t       o_clk,
  output logic                    o_one_wait_state,
  output logic                    o_core_rst,
  output logic                    o_irq
);

  localparam int StopWakeMax = `STOP_WAKE_CYC;
  localparam int StbyWakeMax = `STBY_WAKE_CYC;

  lpm_pkg::lpm_state_t s_r;
  lpm_pkg::lpm_state_t s_nxt;
  lpm_pkg::wake_src_t  lvl;
  lpm_pkg::wake_src_t  rise;
  lpm_pkg::wake_src_t  en_rise;
  lpm_pkg::wake_src_t  stop_mask;
  lpm_pkg::wake_src_t  stby_mask;
  logic                stop_hit;
  logic                stby_hit;
  logic                nocal_hit;
  logic                freq_wr;
  logic                g_ws;
  logic                g_over;
  logic                g_pace;

  wake_sync #(
    .W($bits(lpm_pkg::wake_src_t))
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (i_wake),
    .o_level (lvl),
    .o_rise  (rise)
  );

  assign freq_wr = i_av.write && !s_r.wait_r && (i_av.address == `OFS_FREQ);

  freq_guard u_guard (
    .i_clk            (i_clk),
    .i_rstn           (i_rstn),
    .i_range          (s_r.range),
    .i_src_msi        (s_r.src_msi),
    .i_freq_khz       (s_r.freq),
    .i_freq_wr        (freq_wr),
    .i_new_khz        (i_av.writedata[15:0]),
    .o_one_wait_state (g_ws),
    .o_over_cap       (g_over),
    .o_pace_err       (g_pace)
  );

  // wake source qualification per mode
  always_comb begin
    stop_mask                       = '0;
    stop_mask.ext_interrupt_line    = '1;
    stop_mask.supply_level_detector = 1'b1;
    stop_mask.comp                  = '1;
    stop_mask.usb_wake              = 1'b1;
    stby_mask                       = '0;
    stby_mask.wake_pin              = '1;
    if (s_r.cal_on) begin
      stop_mask.cal_alarm = '1;
      stop_mask.tamper    = 1'b1;
      stop_mask.tstamp    = 1'b1;
      stop_mask.cal_wake  = 1'b1;
      stby_mask.cal_alarm = '1;
      stby_mask.tamper    = 1'b1;
      stby_mask.tstamp    = 1'b1;
      stby_mask.cal_wake  = 1'b1;
    end
    en_rise      = rise & s_r.wake_en;
    // comparator events need the internal reference
    en_rise.comp = en_rise.comp & {2{i_vref_on}};
    stop_hit     = |(en_rise & stop_mask);
    nocal_hit    = !lvl.ext_reset_pin_n || (|en_rise.wake_pin);
    stby_hit     = nocal_hit || (s_r.cal_on && (lvl.wdg_reset || |(en_rise & stby_mask)));
  end

  always_comb begin
    logic [3:0] ev;
    logic       req;
    ev  = 4'h0;
    req = i_av.read || i_av.write;
    s_nxt          = s_r;
    s_nxt.core_rst = 1'b0;

    // avalon slave: one wait cycle, then answer
    if (req && s_r.wait_r) begin
      s_nxt.wait_r = 1'b0;
      case (i_av.address)
        `OFS_CTRL:     s_nxt.rdata = {23'h0, s_r.slowx_en, s_r.slowi_en, s_r.src_msi,
                                      s_r.range, s_r.lp_run, s_r.mode};
        `OFS_FREQ:     s_nxt.rdata = {16'h0, s_r.freq};
        `OFS_STATUS:   s_nxt.rdata = {26'h0, s_r.ws, s_r.clk.reg_lp, s_r.lp_run, s_r.st};
        `OFS_IRQ_STAT: s_nxt.rdata = {28'h0, s_r.irq_stat};
        `OFS_IRQ_MASK: s_nxt.rdata = {28'h0, s_r.irq_mask};
        `OFS_WAKE_EN:  s_nxt.rdata = {2'h0, s_r.wake_en};
        default:       s_nxt.rdata = 32'h0;
      endcase
    end else if (req) begin
      s_nxt.wait_r = 1'b1;
      if (i_av.write) begin
        case (i_av.address)
          `OFS_CTRL: begin
            s_nxt.mode     = i_av.writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            s_nxt.lp_run   = i_av.writedata[`CTRL_LPRUN];
            s_nxt.range    = i_av.writedata[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];
            s_nxt.src_msi  = i_av.writedata[`CTRL_SRC_MSI];
            s_nxt.slowi_en = i_av.writedata[`CTRL_SLOWI];
            s_nxt.slowx_en = i_av.writedata[`CTRL_SLOWX];
          end
          `OFS_FREQ:     s_nxt.freq     = i_av.writedata[15:0];
          `OFS_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~i_av.writedata[3:0];
          `OFS_IRQ_MASK: s_nxt.irq_mask = i_av.writedata[3:0];
          `OFS_WAKE_EN:  s_nxt.wake_en  = i_av.writedata[29:0];
          default: ;
        endcase
      end
    end

    // low-power run only on the lowest multispeed settings
    if (s_nxt.lp_run && (s_nxt.freq > 16'(`LPRUN_MAX_KHZ) || !s_nxt.src_msi)) begin
      s_nxt.lp_run     = 1'b0;
      ev[`IRQ_LPREF]   = 1'b1;
    end
    ev[`IRQ_OVER] = g_over;
    ev[`IRQ_PACE] = g_pace;

    unique case (s_r.st)
      lpm_pkg::ST_RUN: begin
        // the written mode is only entered once the core reports idle
        if (i_cpu_idle) begin
          case (s_r.mode)
            `MODE_SLEEP, `MODE_LPSLEEP: begin
              s_nxt.st       = lpm_pkg::ST_SLEEP;
              s_nxt.lp_sleep = (s_r.mode == `MODE_LPSLEEP);
            end
            `MODE_STOP_CAL, `MODE_STOP_NOCAL: begin
              s_nxt.st     = lpm_pkg::ST_STOP;
              s_nxt.cal_on = (s_r.mode == `MODE_STOP_CAL);
            end
            `MODE_STBY_CAL, `MODE_STBY_NOCAL: begin
              s_nxt.st     = lpm_pkg::ST_STBY;
              s_nxt.cal_on = (s_r.mode == `MODE_STBY_CAL);
            end
            default: ;
          endcase
        end
      end
      lpm_pkg::ST_SLEEP: begin
        if (i_periph_evt || (|en_rise)) begin
          s_nxt.st = lpm_pkg::ST_RUN;
          if (s_r.lp_sleep) begin
            s_nxt.lp_run = 1'b0;
          end
        end
      end
      lpm_pkg::ST_STOP: begin
        if (stop_hit) begin
          s_nxt.st       = lpm_pkg::ST_RUN;
          ev[`IRQ_WAKE]  = 1'b1;
        end
      end
      lpm_pkg::ST_STBY: begin
        if (stby_hit) begin
          s_nxt.st  = lpm_pkg::ST_WAKE;
          s_nxt.cnt = 12'h000;
        end
      end
      lpm_pkg::ST_WAKE: begin
        // core domain lost its contents: restart from reset image, except the wake enables
        if (s_r.cnt == 12'(`REG_SETTLE_CYC - 1)) begin
          s_nxt.st       = lpm_pkg::ST_RUN;
          s_nxt.core_rst = 1'b1;
          s_nxt.mode     = `MODE_SLEEP;
          s_nxt.lp_run   = 1'b0;
          s_nxt.range    = `RANGE_RST;
          s_nxt.src_msi  = `SRC_MSI_RST;
          s_nxt.slowi_en = 1'b0;
          s_nxt.slowx_en = 1'b0;
          s_nxt.freq     = `FREQ_RST;
          s_nxt.irq_mask = 4'h0;
          s_nxt.irq_stat = 4'h0;
          ev[`IRQ_WAKE]  = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
    endcase

    s_nxt.irq_stat = s_nxt.irq_stat | ev; // set beats a same-cycle clear
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
    s_nxt.ws       = g_ws;

    // clock and regulator plan follows the next state
    s_nxt.clk.cpu_en               = 1'b1;
    s_nxt.clk.core_en              = 1'b1;
    s_nxt.clk.pll_en               = !s_nxt.lp_run;
    s_nxt.clk.multispeed_osc_en    = 1'b1;
    s_nxt.clk.fast_internal_osc_en = !s_nxt.lp_run;
    s_nxt.clk.fast_crystal_osc_en  = !s_nxt.lp_run;
    s_nxt.clk.slow_internal_osc_en = s_nxt.slowi_en;
    s_nxt.clk.slow_crystal_osc_en  = s_nxt.slowx_en;
    s_nxt.clk.reg_lp               = s_nxt.lp_run;
    s_nxt.clk.reg_off              = 1'b0;
    s_nxt.clk.core_pwr_off         = 1'b0;
    unique case (s_nxt.st)
      lpm_pkg::ST_RUN: ;
      lpm_pkg::ST_SLEEP: begin
        s_nxt.clk.cpu_en = 1'b0;
        s_nxt.clk.reg_lp = s_nxt.lp_run || s_nxt.lp_sleep;
      end
      lpm_pkg::ST_STOP, lpm_pkg::ST_STBY, lpm_pkg::ST_WAKE: begin
        s_nxt.clk.cpu_en               = 1'b0;
        s_nxt.clk.core_en              = 1'b0;
        s_nxt.clk.pll_en               = 1'b0;
        s_nxt.clk.multispeed_osc_en    = 1'b0;
        s_nxt.clk.fast_internal_osc_en = 1'b0;
        s_nxt.clk.fast_crystal_osc_en  = 1'b0;
        s_nxt.clk.reg_lp               = (s_nxt.st == lpm_pkg::ST_STOP);
        s_nxt.clk.reg_off              = (s_nxt.st == lpm_pkg::ST_STBY);
        s_nxt.clk.core_pwr_off         = (s_nxt.st == lpm_pkg::ST_STBY);
        if (!s_nxt.cal_on && s_nxt.st != lpm_pkg::ST_WAKE) begin
          s_nxt.clk.slow_internal_osc_en = 1'b0;
          s_nxt.clk.slow_crystal_osc_en  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r         <= '0;
      s_r.wait_r  <= 1'b1;
      s_r.range   <= `RANGE_RST;
      s_r.src_msi <= `SRC_MSI_RST;
      s_r.freq    <= `FREQ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_av_readdata    = s_r.rdata;
  assign o_av_waitrequest = s_r.wait_r;
  assign o_clk            = s_r.clk;
  assign o_one_wait_state = s_r.ws;
  assign o_core_rst       = s_r.core_rst;
  assign o_irq            = s_r.irq;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_sleep_cpu_only: assert property (
    s_r.st == lpm_pkg::ST_SLEEP |-> !o_clk.cpu_en && o_clk.core_en)
    else $error("sleep must stop only the cpu clock");

  a_lprun_cap: assert property (
    s_r.st == lpm_pkg::ST_RUN && o_clk.reg_lp |->
      s_r.freq <= 16'(`LPRUN_MAX_KHZ) && s_r.src_msi)
    else $error("low-power run outside multispeed limit");

  a_lpsleep_exit: assert property (
    (s_r.st == lpm_pkg::ST_SLEEP && s_r.lp_sleep) ##1 s_r.st == lpm_pkg::ST_RUN
      |-> !o_clk.reg_lp)
    else $error("regulator not fully on after low-power sleep");

  a_stop_clocks: assert property (
    s_r.st == lpm_pkg::ST_STOP |-> !o_clk.core_en && !o_clk.pll_en &&
      !o_clk.multispeed_osc_en && !o_clk.fast_internal_osc_en &&
      !o_clk.fast_crystal_osc_en && o_clk.reg_lp)
    else $error("stop left a fast clock running");

  a_stop_wake_time: assert property (
    s_r.st == lpm_pkg::ST_STOP && stop_hit |-> ##[1:StopWakeMax] s_r.st == lpm_pkg::ST_RUN)
    else $error("stop wake too slow");

  a_stop_nocal_slow: assert property (
    s_r.st == lpm_pkg::ST_STOP && !s_r.cal_on |->
      !o_clk.slow_internal_osc_en && !o_clk.slow_crystal_osc_en)
    else $error("slow oscillator on in stop without calendar");

  a_standby_off: assert property (
    s_r.st == lpm_pkg::ST_STBY |-> o_clk.reg_off && o_clk.core_pwr_off && !o_clk.cpu_en)
    else $error("standby left regulator or core powered");

  a_standby_exit: assert property (
    s_r.st == lpm_pkg::ST_WAKE |-> s_r.cnt < 12'(StbyWakeMax) && !o_clk.reg_off)
    else $error("standby exit exceeds limit");

  a_standby_nocal: assert property (
    (s_r.st == lpm_pkg::ST_STBY && !s_r.cal_on) ##1 s_r.st == lpm_pkg::ST_WAKE
      |-> $past(nocal_hit))
    else $error("illegal standby exit source");

  a_keep_slow: assert property (
    s_r.st == lpm_pkg::ST_STOP && s_r.cal_on |->
      o_clk.slow_internal_osc_en == s_r.slowi_en &&
      o_clk.slow_crystal_osc_en == s_r.slowx_en)
    else $error("slow oscillator enable changed by stop");

  a_range_flag: assert property (
    (s_r.range == 2'h1 && s_r.freq > 16'(`RANGE1_CAP_KHZ)) ||
    (s_r.range == 2'h2 && s_r.freq > 16'(`RANGE2_CAP_KHZ)) |->
      ##[1:3] s_r.irq_stat[`IRQ_OVER])
    else $error("over-range frequency not flagged");

  a_wait_state: assert property (
    (s_r.range == 2'h2 && s_r.freq > 16'(`RANGE2_WS_KHZ))[*3] |-> o_one_wait_state)
    else $error("wait state missing above threshold");

  a_idle_entry: assert property (
    s_r.st == lpm_pkg::ST_RUN ##1 s_r.st != lpm_pkg::ST_RUN |-> $past(i_cpu_idle))
    else $error("mode entered without idle core");

endmodule : low_power_mode_controller

// ---- dv/wake_source_model.sv ----
`timescale 1ns/1ps

module wake_source_model (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_fire,
  input  wire logic [4:0]   i_sel,
  input  wire logic         i_wfi,
  output lpm_pkg::wake_src_t o_wake,
  output logic              o_cpu_idle
);
  // reset pin held released so standby is left only by the chosen source
  localparam logic [29:0] IDLE_LVL = 30'h20000000;
  logic [29:0] lvl_r;
  logic [3:0]  left_r;

  // a pin stays high eleven cycles: long enough for the three-flop sync
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_r      <= IDLE_LVL;
      left_r     <= 4'h0;
      o_cpu_idle <= 1'b0;
    end else begin
      o_cpu_idle <= i_wfi;
      if (i_fire) begin
        lvl_r[i_sel] <= 1'b1;
        left_r       <= 4'hA;
      end else if (left_r != 4'h0) begin
        left_r <= left_r - 4'h1;
      end else begin
        lvl_r <= IDLE_LVL;
      end
    end
  end

  assign o_wake = lpm_pkg::wake_src_t'(lvl_r);
endmodule : wake_source_model

// ---- dv/low_power_mode_controller_test.sv ----
`timescale 1ns/1ps

module low_power_mode_controller_test;
  logic               i_clk = 1'b0;
  logic               i_rstn = 1'b0;
  lpm_pkg::av_req_t   av = '0;
  logic [31:0]        rdata;
  logic               waitreq;
  logic               periph_evt = 1'b0;
  logic               fire = 1'b0;
  logic [4:0]         sel = 5'h00;
  logic               wfi = 1'b0;
  logic               vref = 1'b0;
  logic               cpu_idle;
  logic               ows;
  logic               core_rst;
  logic               irq;
  lpm_pkg::wake_src_t wake;
  lpm_pkg::clk_ctl_t  clk_o;
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  logic [31:0]        lfsr = 32'hC9262789;
  int                 caps[3] = '{32000, 16000, 4000};
  int                 thrs[3] = '{16000, 8000, 2100};
  int                 fq[$];
  logic [31:0]        q;

  always #12.5 i_clk = ~i_clk;

  low_power_mode_controller DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_av(av), .o_av_readdata(rdata),
    .o_av_waitrequest(waitreq), .i_cpu_idle(cpu_idle), .i_periph_evt(periph_evt),
    .i_vref_on(vref), .i_wake(wake), .o_clk(clk_o), .o_one_wait_state(ows),
    .o_core_rst(core_rst), .o_irq(irq));

  wake_source_model far_side (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_fire(fire), .i_sel(sel), .i_wfi(wfi),
    .o_wake(wake), .o_cpu_idle(cpu_idle));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // request stands until waitrequest is seen low, one idle edge after release
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    av <= '{read: !wr, write: wr, address: a, writedata: d};
    for (k = 0; k < 50; k++) begin
      @(posedge i_clk);
      if (waitreq === 1'b0) break;
    end
    if (k == 50) begin
      n_mismatch++;
      report_and_stop();
    end
    q = rdata;
    av <= '0;
    @(posedge i_clk);
  endtask : bus

  task automatic pulse_wfi();
    wfi <= 1'b1;
    @(posedge i_clk);
    wfi <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : pulse_wfi

  task automatic fire_pin(input int b);
    fire <= 1'b1;
    sel  <= b[4:0];
    @(posedge i_clk);
    fire <= 1'b0;
  endtask : fire_pin

  // sel 0 waits for the cpu clock, 1 for the restart pulse
  task automatic wait_on(input int s, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge i_clk);
      if ((s == 0 ? clk_o.cpu_en : core_rst) === 1'b1) break;
    end
    if (k == lim) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_on

  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    check("clk_run", 32'(clk_o), 32'h7E0);
    bus(0, 8'h00, 0); check("ctrl_rst", q, 32'h60);
    bus(0, 8'h04, 0); check("freq_rst", q, 32'h831);
    bus(0, 8'h1C, 0); check("unmapped", q, 32'h0);
    for (int r = 1; r <= 3; r++) begin
      lfsr = lfsr_next(lfsr);
      fq = {thrs[r-1], thrs[r-1] + 1, int'(lfsr % 32'(caps[r-1]))};
      bus(1, 8'h00, 32'h40 | 32'(r << 4));
      foreach (fq[i]) begin
        bus(1, 8'h04, 32'(fq[i]));
        repeat (3) @(posedge i_clk);
        check("wait_state", 32'(ows), 32'(fq[i] > thrs[r-1]));
      end
    end
    bus(1, 8'h00, 32'h60);
    bus(1, 8'h0C, 32'hF);
    bus(1, 8'h04, 32'd16001);
    repeat (3) @(posedge i_clk);
    bus(0, 8'h0C, 0); check("over_cap", 32'(q[2]), 32'h1);
    bus(1, 8'h04, 32'd2000);
    repeat (205) @(posedge i_clk);
    bus(1, 8'h0C, 32'hF);
    bus(0, 8'h0C, 0); check("pace_clear", q, 32'h0);
    bus(1, 8'h04, 32'd9000);
    repeat (3) @(posedge i_clk);
    bus(0, 8'h0C, 0); check("pace", 32'(q[3]), 32'h1);
    bus(1, 8'h04, 32'd2000);
    bus(1, 8'h0C, 32'hF);
    bus(1, 8'h00, 32'h68);
    bus(0, 8'h00, 0); check("lprun_refused", q, 32'h60);
    bus(0, 8'h0C, 0); check("lprun_flag", 32'(q[1]), 32'h1);
    check("reg_lp_off", 32'(clk_o.reg_lp), 32'h0);
    bus(1, 8'h04, 32'd131);
    bus(1, 8'h00, 32'h68);
    repeat (3) @(posedge i_clk);
    check("reg_lp_on", 32'(clk_o.reg_lp), 32'h1);
    bus(1, 8'h00, 32'h69);
    pulse_wfi();
    check("lpsleep", 32'({clk_o.cpu_en, clk_o.reg_lp}), 32'h1);
    periph_evt <= 1'b1;
    @(posedge i_clk);
    periph_evt <= 1'b0;
    wait_on(0, 20);
    check("lpsleep_exit", 32'(clk_o.reg_lp), 32'h0);
    bus(0, 8'h00, 0); check("lpsleep_ctrl", q, 32'h61);
    bus(1, 8'h00, 32'h60);
    pulse_wfi();
    check("sleep", 32'({clk_o.cpu_en, clk_o.core_en, clk_o.fast_internal_osc_en}),
          32'h3);
    periph_evt <= 1'b1;
    @(posedge i_clk);
    periph_evt <= 1'b0;
    wait_on(0, 20);
    bus(1, 8'h14, 32'h00820008);
    bus(1, 8'h10, 32'h1);
    bus(1, 8'h0C, 32'hF);
    bus(1, 8'h00, 32'hE2);
    pulse_wfi();
    check("stop_cal", 32'(clk_o), 32'h014);
    check("irq_idle", 32'(irq), 32'h0);
    fire_pin(3);
    wait_on(0, 320);
    repeat (2) @(posedge i_clk);
    check("irq_wake", 32'(irq), 32'h1);
    bus(1, 8'h0C, 32'h1);
    repeat (2) @(posedge i_clk);
    check("irq_clear", 32'(irq), 32'h0);
    bus(1, 8'h00, 32'h1E3);
    pulse_wfi();
    check("stop_nocal", 32'(clk_o), 32'h004);
    fire_pin(23);
    repeat (30) @(posedge i_clk);
    check("stop_cal_src", 32'(clk_o.cpu_en), 32'h0);
    fire_pin(17);
    repeat (30) @(posedge i_clk);
    check("comp_no_ref", 32'(clk_o.cpu_en), 32'h0);
    vref <= 1'b1;
    fire_pin(17);
    wait_on(0, 320);
    bus(1, 8'h14, 32'h02800000);
    bus(1, 8'h00, 32'h65);
    pulse_wfi();
    check("stby", 32'(clk_o & 11'h61B), 32'h003);
    fire_pin(23);
    repeat (30) @(posedge i_clk);
    check("stby_cal_src", 32'(clk_o.cpu_en), 32'h0);
    fire_pin(25);
    wait_on(1, 2400);
    repeat (2) @(posedge i_clk);
    bus(0, 8'h00, 0); check("stby_ctrl", q, 32'h60);
    bus(0, 8'h0C, 0); check("stby_flag", q, 32'h1);
    bus(0, 8'h14, 0); check("wake_kept", q, 32'h02800000);
    bus(1, 8'h00, 32'h64);
    pulse_wfi();
    check("stby_cal", 32'(clk_o & 11'h61B), 32'h003);
    fire_pin(23);
    wait_on(1, 2400);
    report_and_stop();
  end
endmodule : low_power_mode_controller_test
